// ---- rtl/iam_top.v ----
/*
 * Index address modifier: adds four-digit index registers, read one
 * character at a time from main memory, into the B and A address
 * fields, digit by digit, under a six-step sequencer.
 * Assumes a same-clock memory that answers each read strobe with
 * one valid pulse, and an AXI4-Lite register master.
 */
//
// Summary of operation
// - Start only when operation code equals 1001
// - Step 0 reads B index digit
// - Fault at count zero checks; count four clears minus
// - Step 1 loads B field digit to addend
// - Step 2 writes sum into B digit
// - B store at 3T, decrement, loop
// - Step 3 reads A index digit
// - A no-indexing in step 3 exits
// - Step 4 loads A field digit to addend
// - Step 5 writes sum into A digit
// - Decrement, back to step 3, clear indexing
`include "iam_regs.vh"

module iam_top #(
    parameter AW = 16                        // Memory address width
) (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire [7:0]    s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [7:0]    s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    output reg           mem_rd_q,
    output reg  [AW-1:0] mem_addr_q,
    input  wire          mem_rvalid,
    input  wire [3:0]    mem_rdata,
    input  wire          mem_data_fault,
    output reg  [3:0]    internal_bus_q,
    output reg           irq_q
);

    // Sequencer steps
    localparam [2:0] ST_RD_B = 3'd0;
    localparam [2:0] ST_IX_B = 3'd1;
    localparam [2:0] ST_ST_B = 3'd2;
    localparam [2:0] ST_RD_A = 3'd3;
    localparam [2:0] ST_IX_A = 3'd4;
    localparam [2:0] ST_ST_A = 3'd5;

    reg          busy_q;                    // Algorithm running
    reg  [2:0]   step_q;                    // Current step
    reg  [1:0]   phase_q;                   // Step clock phase 0T..3T
    reg  [2:0]   pos_q;                     // Digit-position counter
    reg          rd_wait_q;                 // Memory read outstanding
    reg  [3:0]   idx_digit_q;               // Index-digit holding reg
    reg  [3:0]   addend_q;                  // Addend register
    reg          carry_q;                   // Carry/borrow between digits
    reg          minus_q;                   // Subtract control
    reg          check_q;                   // Check condition
    reg          b_noix_q;                  // second_operand_no_indexing
    reg          a_noix_q;                  // first_operand_no_indexing
    reg  [7:0]   ctrl_q;                    // Control register image
    reg  [15:0]  bfield_q;                  // B address field, BCD
    reg  [15:0]  afield_q;                  // A address field, BCD
    reg  [AW-1:0] bix_loc_q;                // B index register location
    reg  [AW-1:0] aix_loc_q;                // A index register location
    reg  [1:0]   int_stat_q;                // Sticky events
    reg  [1:0]   int_mask_q;                // Event mask
    reg          aw_got_q;                  // Write address held
    reg          w_got_q;                   // Write data held
    reg  [7:0]   awaddr_q;
    reg  [31:0]  wdata_q;

    // Digit selected by counter: 4->0, 3->1, 2->2, 1->3
    wire [1:0]   dig_sel = 2'd3 - pos_q[1:0] + 2'd1;
    wire [AW-1:0] dig_ofs = {{(AW-2){1'b0}}, dig_sel};
    wire         store_ph = (phase_q == `IAM_STORE_PHASE);

    // Write and read decode
    wire         wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
    wire         rd_fire = s_axi_arvalid && s_axi_arready;
    wire         wr_ctrl = wr_fire && awaddr_q == `IAM_CTRL_OFS;
    wire         go_req  = wr_ctrl && wdata_q[`IAM_CTRL_GO] && !busy_q;
    wire         rd_istat = rd_fire && s_axi_araddr == `IAM_INTSTAT_OFS;

    // Events raised by the sequencer
    reg          ev_done_q;
    reg          ev_check_q;

    reg  [4:0]   raw;
    reg  [3:0]   sum_digit;
    reg          sum_carry;
    always @* begin
        raw = 5'd0;
        if (!minus_q) begin
            raw = {1'b0, idx_digit_q} + {1'b0, addend_q} + {4'd0, carry_q};
            sum_carry = (raw > 5'd9);
            // Decimal correction wraps above nine
            sum_digit = sum_carry ? raw[3:0] + 4'd6 : raw[3:0];
        end else begin
            raw = {1'b0, addend_q} - {1'b0, idx_digit_q}
                  - {4'd0, carry_q};
            sum_carry = raw[4];
            // Borrow: tens complement correction
            sum_digit = sum_carry ? raw[3:0] - 4'd6 : raw[3:0];
        end
    end

    // Selected digit of each address field
    wire [3:0] b_dig = bfield_q[15 - 4*dig_sel -: 4];
    wire [3:0] a_dig = afield_q[15 - 4*dig_sel -: 4];

    // Index sequencer
    always @(posedge aclk) begin
        ev_done_q  <= 1'b0;
        ev_check_q <= 1'b0;
        if (!aresetn) begin
            busy_q      <= 1'b0;
            step_q      <= ST_RD_B;
            phase_q     <= 2'd0;
            pos_q       <= `IAM_Q_ZERO;
            rd_wait_q   <= 1'b0;
            mem_rd_q    <= 1'b0;
            mem_addr_q  <= {AW{1'b0}};
            idx_digit_q <= 4'h0;
            addend_q    <= 4'h0;
            carry_q     <= 1'b0;
            minus_q     <= 1'b0;
            check_q     <= 1'b0;
            b_noix_q    <= 1'b0;
            a_noix_q    <= 1'b0;
            internal_bus_q <= 4'h0;
            bfield_q    <= `IAM_FIELD_RST;
            afield_q    <= `IAM_FIELD_RST;
        end else begin
            mem_rd_q <= 1'b0;
            // Fields writable only while idle
            if (wr_fire && !busy_q && awaddr_q == `IAM_BFIELD_OFS)
                bfield_q <= wdata_q[15:0];
            if (wr_fire && !busy_q && awaddr_q == `IAM_AFIELD_OFS)
                afield_q <= wdata_q[15:0];
            if (wr_ctrl && !busy_q)
                minus_q <= wdata_q[`IAM_CTRL_MINUS];
            if (go_req && wdata_q[`IAM_CTRL_OP_HI:`IAM_CTRL_OP_LO]
                    == `IAM_OP_INDEX) begin
                busy_q   <= 1'b1;
                step_q   <= ST_RD_B;
                phase_q  <= 2'd0;
                pos_q    <= `IAM_Q_FIRST;
                check_q  <= 1'b0;
                b_noix_q <= wdata_q[`IAM_CTRL_BNOIX];
                a_noix_q <= wdata_q[`IAM_CTRL_ANOIX];
            end else if (busy_q) begin
                phase_q <= phase_q + 2'd1;
                case (step_q)
                    ST_RD_B, ST_RD_A: begin
                        if (step_q == ST_RD_A && a_noix_q) begin
                            busy_q  <= 1'b0;
                            ev_done_q <= 1'b1;
                        end else if (!rd_wait_q) begin
                            mem_addr_q <= (step_q == ST_RD_B ?
                                bix_loc_q : aix_loc_q) + dig_ofs;
                            mem_rd_q  <= 1'b1;
                            rd_wait_q <= 1'b1;
                            phase_q   <= 2'd0;
                        end else if (mem_rvalid) begin
                            rd_wait_q   <= 1'b0;
                            idx_digit_q <= mem_rdata;
                            internal_bus_q <= mem_rdata;
                            if (pos_q == `IAM_Q_ZERO && mem_data_fault) begin
                                check_q  <= 1'b1;
                                ev_check_q <= 1'b1;
                            end
                            if (pos_q == `IAM_Q_FIRST) begin
                                minus_q <= 1'b0;
                                carry_q <= 1'b0;
                            end
                            step_q  <= step_q + 3'd1;
                            phase_q <= 2'd0;
                        end else begin
                            // Hold phase while memory answers
                            phase_q <= 2'd0;
                        end
                    end
                    ST_IX_B: begin
                        addend_q       <= b_dig;
                        internal_bus_q <= b_dig;
                        step_q  <= ST_ST_B;
                        phase_q <= 2'd0;
                    end
                    ST_IX_A: begin
                        addend_q       <= a_dig;
                        internal_bus_q <= a_dig;
                        step_q  <= ST_ST_A;
                        phase_q <= 2'd0;
                    end
                    ST_ST_B: begin
                        internal_bus_q <= sum_digit;
                        if (store_ph) begin
                            bfield_q[15 - 4*dig_sel -: 4] <= sum_digit;
                            carry_q <= sum_carry;
                            pos_q   <= pos_q - 3'd1;
                            phase_q <= 2'd0;
                            if (pos_q == `IAM_Q_LAST || b_noix_q) begin
                                step_q  <= ST_RD_A;
                                pos_q   <= `IAM_Q_FIRST;
                            end else begin
                                step_q  <= ST_RD_B;
                            end
                        end
                    end
                    ST_ST_A: begin
                        internal_bus_q <= sum_digit;
                        if (store_ph) begin
                            afield_q[15 - 4*dig_sel -: 4] <= sum_digit;
                            carry_q <= sum_carry;
                            pos_q   <= pos_q - 3'd1;
                            step_q  <= ST_RD_A;
                            phase_q <= 2'd0;
                            if (pos_q == `IAM_Q_LAST)
                                a_noix_q <= 1'b1;
                        end
                    end
                    default: begin
                        // Unused code: abandon cleanly
                        busy_q <= 1'b0;
                        step_q <= ST_RD_B;
                    end
                endcase
            end
        end
    end

    // Sticky events, mask and interrupt; set wins over read-clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            int_stat_q <= 2'b00;
            int_mask_q <= `IAM_MASK_RST;
            ctrl_q     <= 8'h00;
            bix_loc_q  <= {AW{1'b0}};
            aix_loc_q  <= {AW{1'b0}};
            irq_q      <= 1'b0;
        end else begin
            int_stat_q <= (rd_istat ? 2'b00 : int_stat_q)
                          | {ev_check_q, ev_done_q};
            irq_q <= |(int_stat_q & int_mask_q);
            if (wr_fire && awaddr_q == `IAM_INTMASK_OFS)
                int_mask_q <= wdata_q[1:0];
            if (wr_ctrl)
                ctrl_q <= {wdata_q[7:1], 1'b0};
            // Locations fixed while running
            if (wr_fire && !busy_q && awaddr_q == `IAM_BIXLOC_OFS)
                bix_loc_q <= wdata_q[AW-1:0];
            if (wr_fire && !busy_q && awaddr_q == `IAM_AIXLOC_OFS)
                aix_loc_q <= wdata_q[AW-1:0];
        end
    end

    // AXI write channels: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
        end else begin
            s_axi_awready <= !aw_got_q && !s_axi_awready;
            s_axi_wready  <= !w_got_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q      <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q      <= 1'b1;
                wdata_q      <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                // Unmapped or unaligned: slave error
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q[1:0] != 2'b00 ||
                    awaddr_q > `IAM_INTMASK_OFS) ? 2'b10 : 2'b00;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
            end
        end
    end

    // AXI read channel: one read at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'b00;
                case (s_axi_araddr)
                    `IAM_CTRL_OFS:    s_axi_rdata <= {24'h0, ctrl_q};
                    `IAM_STATUS_OFS:  s_axi_rdata <= {22'h0, a_noix_q,
                        b_noix_q, check_q, pos_q, step_q, busy_q};
                    `IAM_BFIELD_OFS:  s_axi_rdata <= {16'h0, bfield_q};
                    `IAM_AFIELD_OFS:  s_axi_rdata <= {16'h0, afield_q};
                    `IAM_BIXLOC_OFS:  s_axi_rdata <= {{(32-AW){1'b0}},
                        bix_loc_q};
                    `IAM_AIXLOC_OFS:  s_axi_rdata <= {{(32-AW){1'b0}},
                        aix_loc_q};
                    `IAM_INTSTAT_OFS: s_axi_rdata <= {30'h0, int_stat_q};
                    `IAM_INTMASK_OFS: s_axi_rdata <= {30'h0, int_mask_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ---- rtl/iam_regs.vh ----
/*
 * Register offsets, field positions, reset values and timing counts
 * for the index address modifier.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`ifndef IAM_REGS_VH
`define IAM_REGS_VH

// Register byte offsets
`define IAM_CTRL_OFS      8'h00
`define IAM_STATUS_OFS    8'h04
`define IAM_BFIELD_OFS    8'h08
`define IAM_AFIELD_OFS    8'h0c
`define IAM_BIXLOC_OFS    8'h10
`define IAM_AIXLOC_OFS    8'h14
`define IAM_INTSTAT_OFS   8'h18
`define IAM_INTMASK_OFS   8'h1c

// Control register fields
`define IAM_CTRL_GO       0
`define IAM_CTRL_MINUS    1
`define IAM_CTRL_BNOIX    2
`define IAM_CTRL_ANOIX    3
`define IAM_CTRL_OP_LO    4
`define IAM_CTRL_OP_HI    7

// Operation code that selects the index algorithm
`define IAM_OP_INDEX      4'h9

// Interrupt status bit positions
`define IAM_INT_DONE      0
`define IAM_INT_CHECK     1

// Position counter values and store phase
`define IAM_Q_FIRST       3'h4
`define IAM_Q_LAST        3'h1
`define IAM_Q_ZERO        3'h0
`define IAM_STORE_PHASE   2'h3

// Reset values
`define IAM_FIELD_RST     16'h0000
`define IAM_MASK_RST      2'h0

`endif

// ---- test/iam_top_asserts.sv ----
/* Port checker for the index address modifier top level.
   Assumes one clock and a synchronous active-low reset. */
module iam_top_asserts #(
    parameter AW = 16               // Memory address width
) (
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic          s_axi_wvalid,
    input wire logic          s_axi_wready,
    input wire logic [1:0]    s_axi_bresp,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic [7:0]    s_axi_araddr,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic [31:0]   s_axi_rdata,
    input wire logic [1:0]    s_axi_rresp,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_rready,
    input wire logic          mem_rd_q,
    input wire logic [AW-1:0] mem_addr_q,
    input wire logic          mem_rvalid,
    input wire logic          irq_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rd_one_pulse: assert property (mem_rd_q |=> !mem_rd_q)
        else $error("memory read strobe longer than one cycle");
    a_addr_held_idle: assert property (!mem_rd_q |-> $stable(mem_addr_q))
        else $error("memory address moved without a read");
    a_store_gap: assert property (mem_rvalid |=> !mem_rd_q [*3])
        else $error("next read came before the store phase");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before rready");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr > 8'h1c || s_axi_araddr[1:0] != 2'h0)
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready held two cycles");
    // Main scenarios reached
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_mem_read: cover property (mem_rd_q ##[1:20] mem_rvalid);
    c_irq: cover property ($rose(irq_q));
endmodule

bind iam_top iam_top_asserts #(.AW(AW)) u_chk (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q),
    .mem_rvalid(mem_rvalid), .irq_q(irq_q));

// ---- test/iam_mem_model.sv ----
/* Behavioural character-serial memory answering index digit reads.
   Assumes a one-cycle read strobe on the same clock as the block. */
module iam_mem_model (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        mem_rd_q,
    input wire logic [15:0] mem_addr_q,
    output logic            mem_rvalid,
    output logic [3:0]      mem_rdata,
    output logic            mem_data_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  mem [0:1023];      // Digit store, filled by the bench
    int          lat = 0;           // Idle cycles before each answer
    logic        fault_en = 1'b0;   // Flag a fault with each answer
    logic        pend_q = 1'b0;     // Read waiting for its answer
    int          cnt_q = 0;         // Remaining delay
    logic [15:0] addr_q = 16'h0000; // Captured address
    initial foreach (mem[i]) mem[i] = 4'h0;
    // Data lines toggle when idle so a stale digit cannot pass for good
    always @(posedge aclk) begin
        mem_rvalid <= 1'b0;
        mem_data_fault <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!aresetn) begin
            pend_q <= 1'b0;
        end else if (mem_rd_q) begin
            pend_q <= 1'b1;
            cnt_q <= lat;
            addr_q <= mem_addr_q;
        end else if (pend_q && cnt_q == 0) begin
            pend_q <= 1'b0;
            mem_rvalid <= 1'b1;
            mem_rdata <= mem[addr_q[9:0]];
            mem_data_fault <= fault_en;
        end else if (pend_q) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule

// ---- test/iam_top_bench.sv ----
/* Self-checking bench for the index address modifier.
   Assumes the memory model answers every read strobe. */
`include "iam_regs.vh"
module iam_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic [31:0] last_data; // Last read word
    logic        mem_rd_q, mem_rvalid, mem_data_fault, irq_q;
    logic [15:0] mem_addr_q;
    logic [3:0]  mem_rdata, internal_bus_q;
    logic [15:0] rd_log [$]; // Addresses of memory reads
    int          n_errors = 0, samples_checked = 0;
    always #5 aclk = ~aclk;
    iam_top #(.AW(16)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .mem_rd_q(mem_rd_q),
        .mem_addr_q(mem_addr_q), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .mem_data_fault(mem_data_fault),
        .internal_bus_q(internal_bus_q), .irq_q(irq_q));
    iam_mem_model m (.aclk(aclk), .aresetn(aresetn), .mem_rd_q(mem_rd_q),
        .mem_addr_q(mem_addr_q), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .mem_data_fault(mem_data_fault));
    // Log every read strobe for order checks
    always @(posedge aclk) begin
        if (mem_rd_q === 1'b1) rd_log.push_back(mem_addr_q);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        last_data = s_axi_rdata;
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Decimal add, carry moving from digit 0 (top nibble) downward
    function automatic logic [15:0] bcd_add(input logic [15:0] f,
                                            input logic [15:0] x);
        logic [4:0] s;
        logic       c;
        c = 1'b0;
        for (int k = 0; k < 4; k++) begin
            s = f[15-4*k -: 4] + x[15-4*k -: 4] + c;
            c = (s > 9);
            if (c) s = s - 5'd10;
            bcd_add[15-4*k -: 4] = s[3:0];
        end
    endfunction
    task automatic setup(input logic [15:0] bl, input logic [15:0] bi);
        for (int k = 0; k < 4; k++) m.mem[bl[9:0] + k] = bi[15-4*k -: 4];
        for (int k = 0; k < 4; k++) m.mem[10'h200 + k] = 4'h5 * k[0];
        axi_write(`IAM_BFIELD_OFS, 32'h1234);
        axi_write(`IAM_AFIELD_OFS, 32'h5678);
        axi_write(`IAM_BIXLOC_OFS, {16'h0, bl});
        axi_write(`IAM_AIXLOC_OFS, 32'h0200);
        rd_log.delete();
    endtask
    task automatic test_regs;
        axi_read(`IAM_BFIELD_OFS);
        check(last_data, 32'h0, "field reset");
        axi_read(`IAM_INTMASK_OFS);
        check(last_data, 32'h0, "mask reset");
        axi_write(`IAM_AFIELD_OFS, 32'h9876);
        axi_read(`IAM_AFIELD_OFS);
        check(last_data, 32'h9876, "readback");
        axi_read(8'h20);
        check({last_resp, last_data[29:0]}, 32'h80000000, "unmapped");
        axi_write(8'h06, 32'h1);
        check(last_resp, 2'b10, "unaligned");
        $display("test regs done");
    endtask
    task automatic test_full(input int l, input logic [7:0] ctrl,
                             input logic fe);
        m.lat = l;
        m.fault_en = fe;
        setup(16'h0100, 16'h1999);
        axi_write(`IAM_INTMASK_OFS, 32'h1);
        axi_write(`IAM_CTRL_OFS, {24'h0, ctrl});
        for (int n = 0; n < 3000 && irq_q !== 1'b1; n++)
            @(posedge aclk);
        check(irq_q, 1'b1, "irq");
        axi_read(`IAM_BFIELD_OFS);
        check(last_data, bcd_add(16'h1234, 16'h1999), "b sum");
        axi_read(`IAM_AFIELD_OFS);
        check(last_data, bcd_add(16'h5678, 16'h0505), "a sum");
        check(rd_log.size(), 8, "reads");
        for (int k = 0; k < 8; k++)
            check(rd_log[k], k < 4 ? 16'h0100 + k : 16'h01fc + k, "addr");
        axi_read(`IAM_STATUS_OFS);
        check(last_data[7], 1'b0, "check flag");
        axi_read(`IAM_INTSTAT_OFS);
        check(last_data, 32'h1, "done flag");
        axi_read(`IAM_INTSTAT_OFS);
        check(last_data, 32'h0, "read clear");
        repeat (2) @(posedge aclk);
        check(irq_q, 1'b0, "irq clear");
        $display("test full latency %0d done", l);
    endtask
    task automatic test_noix;
        setup(16'h0300, 16'h7999);
        axi_write(`IAM_INTMASK_OFS, 32'h0);
        axi_write(`IAM_CTRL_OFS, 32'h9d);
        last_data = 32'h1;
        for (int n = 0; n < 300 && last_data[0] !== 1'b0; n++)
            axi_read(`IAM_STATUS_OFS);
        check(last_data[0], 1'b0, "idle");
        axi_read(`IAM_BFIELD_OFS);
        check(last_data, 32'h8234, "b digit 0");
        axi_read(`IAM_AFIELD_OFS);
        check(last_data, 32'h5678, "a kept");
        check(rd_log.size(), 1, "reads");
        check(rd_log[0], 16'h0300, "read addr");
        check(internal_bus_q, 4'h8, "bus sum");
        check(irq_q, 1'b0, "irq masked");
        axi_read(`IAM_INTSTAT_OFS);
        check(last_data, 32'h1, "done flag");
        $display("test no indexing done");
    endtask
    task automatic test_opcodes;
        for (int op = 0; op < 16; op++) begin
            if (op != 9) begin
                rd_log.delete();
                axi_write(`IAM_CTRL_OFS, {24'h0, op[3:0], 4'h1});
                repeat (8) @(posedge aclk);
                axi_read(`IAM_STATUS_OFS);
                check(last_data[0], 1'b0, "bad op idle");
                check(rd_log.size(), 0, "bad op reads");
            end
        end
        $display("test opcodes done");
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence; minus control set in the slow run must not subtract
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        test_regs;
        test_full(0, 8'h91, 1'b0);
        test_full(3, 8'h93, 1'b1);
        test_noix;
        test_opcodes;
        give_verdict;
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #200us;
        n_errors++;
        $display("ERROR %0t watchdog expired", $time);
        give_verdict;
    end
endmodule
